// file: common/tcc_pkg.sv
// Purpose: constants for the toggle/supply/debounce configuration bank
// Assumes: 250 MHz core clock, registers written by the internal serial-bus engine
// Notes: times kept in ms; cycle counts derived from the clock period
// Function
// RULE1 - period field 7:6 selects 60..90 ms
// RULE2 - duty field splits period sink/source
// RULE3 - source pull-up current from 2-bit field
// RULE4 - global mask resets 1, blocks all
// RULE5 - global mask 0: per-source masks decide
// RULE6 - weak-supply threshold select 3.0..3.3 V
// RULE7 - weak supply with enable forces sink role
// RULE8 - supply recovery restores saved port role
// RULE9 - enable bit honoured only in bus mode
// RULE10 - enable 0 disables main state machine
// RULE11 - attach debounce 120..180 ms, 111 reserved
// RULE12 - fixed-duty override alternates every 500 ms
// RULE13 - role bits decode; change triggers error recovery
// RULE14 - status set even when source masked
// RULE15 - reserved bits read back, no effect
// RULE16 - new settings applied at next interval start
`default_nettype none
package tcc_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_TOGGLE_IRQ = 8'h04;
  localparam logic [7:0] ADDR_SUPPLY_DEB = 8'h05;
  localparam logic [7:0] RST_TOGGLE_IRQ = 8'h41;
  localparam logic [7:0] RST_SUPPLY_DEB = 8'h23;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int PERIOD_LSB = 6;
  localparam int DUTY_LSB = 4;
  localparam int CUR_LSB = 1;
  localparam int GMASK_BIT = 0;
  localparam int THR_LSB = 5;
  localparam int FALLBACK_BIT = 4;
  localparam int ENABLE_BIT = 3;
  localparam int DEB_LSB = 0;
  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  localparam logic [2:0] ROLE_SINK = 3'h2;
  localparam logic [1:0] CUR_RESERVED = 2'h0;
  localparam logic [1:0] CUR_DEFAULT = 2'h1;
  localparam logic [2:0] DEB_RESERVED = 3'h7;
  // ------------------------------------------------------------
  // times
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PS_PER_MS = 1000000000;
  localparam int MS_CYCLES = PS_PER_MS / CLK_PERIOD_PS;
  localparam int PERIOD_BASE_MS = 60;
  localparam int PERIOD_STEP_MS = 10;
  localparam int SINK_PCT_BASE = 60;
  localparam int PCT_STEP = 10;
  localparam int FIXED_DUTY_MS = 500;
  localparam int DEB_BASE_MS = 120;
  localparam int DEB_STEP_MS = 10;
  localparam int DEB_MAX_MS = 180;
endpackage
`default_nettype wire

// file: dv/tcc_host_model.sv
// Purpose: far-side model: register-bus engine plus the port-role register
// Assumes: one write strobe per cycle, read data valid one edge after address
// Notes: write data is inverted once the strobe drops, so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none
module tcc_host_model (
  input wire logic CLK,
  output logic REG_WE,
  output logic [7:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic ROLE_WR,
  input wire logic [2:0] ROLE_WDATA,
  output logic [2:0] PORT_ROLE_CFG
);
  // ----------------------------------------
  // port-role register, starts as dual-role
  // ----------------------------------------
  initial begin
    REG_WE = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    PORT_ROLE_CFG = 3'h4;
  end
  // takes the bank's force and restore requests
  always @(posedge CLK) begin
    if (ROLE_WR) begin
      PORT_ROLE_CFG <= ROLE_WDATA;
    end
  end
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // single-byte write, strobe held for exactly one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_WE <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WE <= 1'b0;
    REG_WDATA <= ~d;
  endtask
  // read data is registered, so look one edge after the address lands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    @(posedge CLK);
    #1;
    d = REG_RDATA;
  endtask
endmodule
`default_nettype wire

// file: dv/test_typec_timing_config_regs.sv
// Purpose: self-checking bench for the toggle/supply/debounce configuration bank
// Assumes: ms tick shortened to 4 cycles so whole toggle periods fit the run
// Notes: fixed-duty override checked by movement and 9 ms grid alignment; its phase after reset is not predicted
`timescale 1ns/1ps
`default_nettype none
module test_typec_timing_config_regs;
  localparam int MS = 4;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic BUS_MODE = 1'b1;
  logic FIXED_DUTY_EN = 1'b0;
  logic VDD_LOW = 1'b0;
  logic ATTACH_RAW = 1'b0;
  logic [7:0] IRQ_STATUS = 8'h00, IRQ_FILTER = 8'h00, SECOND_IRQ_STATUS = 8'h00, SECOND_IRQ_FILTER = 8'h00;
  logic REG_WE, INT_N, PRESENT_SOURCE, ATTACH_VALID, HOST_DISABLED_STATE, ERR_RECOVERY, ROLE_WR;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
  logic [2:0] PORT_ROLE_CFG, ROLE_WDATA;
  logic [1:0] WEAK_SUPPLY_THRESHOLD_SEL, SOURCE_PULLUP_CURRENT_SEL;
  logic [2:0] codes [3] = '{3'h0, 3'h6, 3'h7};
  int mismatches = 0;
  int n_tests = 0;
  // ----------------------------------------
  // clock, design and far side
  // ----------------------------------------
  always #2 CLK = ~CLK;
  tcc_cfg_regs #(.MS_CYC(MS)) tcc_cfg_regs_inst (.CLK(CLK), .RSTN(RSTN), .REG_WE(REG_WE),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .BUS_MODE(BUS_MODE),
    .FIXED_DUTY_EN(FIXED_DUTY_EN), .PORT_ROLE_CFG(PORT_ROLE_CFG), .IRQ_STATUS(IRQ_STATUS),
    .IRQ_FILTER(IRQ_FILTER), .SECOND_IRQ_STATUS(SECOND_IRQ_STATUS), .SECOND_IRQ_FILTER(SECOND_IRQ_FILTER),
    .VDD_LOW(VDD_LOW), .ATTACH_RAW(ATTACH_RAW), .INT_N(INT_N),
    .WEAK_SUPPLY_THRESHOLD_SEL(WEAK_SUPPLY_THRESHOLD_SEL), .SOURCE_PULLUP_CURRENT_SEL(SOURCE_PULLUP_CURRENT_SEL),
    .PRESENT_SOURCE(PRESENT_SOURCE), .ATTACH_VALID(ATTACH_VALID), .HOST_DISABLED_STATE(HOST_DISABLED_STATE),
    .ERR_RECOVERY(ERR_RECOVERY), .ROLE_WR(ROLE_WR), .ROLE_WDATA(ROLE_WDATA));
  tcc_host_model tcc_host_model_inst (.CLK(CLK), .REG_WE(REG_WE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .ROLE_WR(ROLE_WR), .ROLE_WDATA(ROLE_WDATA), .PORT_ROLE_CFG(PORT_ROLE_CFG));
  // ----------------------------------------
  // expectations and helpers
  // ----------------------------------------
  // source share of a period in cycles; sink share comes first
  function automatic int src_cyc(input int p, input int d);
    return ((60 + 10 * p) - (60 + 10 * p) * (60 - 10 * d) / 100) * MS;
  endfunction
  // low only when an unmasked status bit exists and the global mask is off
  function automatic logic irq_exp(input logic [7:0] s, f, s2, f2, input logic gm);
    return gm | ~(|(s & ~f) | |(s2 & ~f2));
  endfunction
  function automatic logic sig(input int w);
    case (w)
      0: return ROLE_WR;
      1: return ERR_RECOVERY;
      2: return PRESENT_SOURCE;
      default: return ATTACH_VALID;
    endcase
  endfunction
  task automatic close_out();
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // tolerance only for counted durations, which carry synchroniser slack
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol = 0);
    n_tests++;
    if (tol == 0 ? got !== exp : (got > exp + tol || got + tol < exp)) begin
      mismatches++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // bounded wait for a level, returns the edges spent
  task automatic wt(input int w, input logic lvl, input int lim, output int n);
    n = 0;
    while (sig(w) !== lvl && n < lim) begin
      @(posedge CLK);
      #1;
      n++;
    end
    if (n >= lim) begin
      mismatches++;
      $display("[ERR] %0t wait %0h gave up after %0h", $time, w, n);
      close_out();
    end
  endtask
  // length of the second source share to begin from now, in edges
  task automatic src_len(output int n);
    wt(2, 0, 500, n);
    wt(2, 1, 500, n);
    wt(2, 0, 500, n);
    wt(2, 1, 500, n);
    wt(2, 0, 500, n);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int n, n1;
    logic [7:0] r, a, d, s, f, s2, f2;
    logic bm, gm;
    void'($urandom(60056));
    repeat (5) @(posedge CLK);
    RSTN <= 1'b1;
    // reset contents, unmapped place
    tcc_host_model_inst.rd(8'h04, r);
    chk(r, 8'h41);
    tcc_host_model_inst.rd(8'h05, r);
    chk(r, 8'h23);
    chk(INT_N, 1'b1);
    chk(SOURCE_PULLUP_CURRENT_SEL, 2'h1);
    chk(HOST_DISABLED_STATE, 1'b1);
    tcc_host_model_inst.wr(8'h06, 8'hff);
    tcc_host_model_inst.rd(8'h06, r);
    chk(r, 8'h00);
    tcc_host_model_inst.rd(8'h04, r);
    chk(r, 8'h41);
    // random writes and readback, mode flips; reserved encodings avoided
    for (int i = 0; i < 8; i++) begin
      a = 8'h04 + 8'($urandom_range(1));
      d = 8'($urandom());
      bm = 1'($urandom());
      if (a == 8'h04 && d[2:1] == 2'h0) d[1] = 1'b1;
      if (a == 8'h05 && d[2:0] == 3'h7) d[0] = 1'b0;
      @(posedge CLK);
      BUS_MODE <= bm;
      tcc_host_model_inst.wr(a, d);
      tcc_host_model_inst.rd(a, r);
      chk(r, d);
      if (a == 8'h05) begin
        chk(WEAK_SUPPLY_THRESHOLD_SEL, d[6:5]);
        chk(HOST_DISABLED_STATE, bm & ~d[3]);
      end
    end
    @(posedge CLK);
    BUS_MODE <= 1'b1;
    tcc_host_model_inst.wr(8'h05, 8'h2b);
    // interrupt gating, first three cases are corners
    for (int i = 0; i < 8; i++) begin
      s = (i < 3) ? 8'hff : 8'($urandom());
      f = (i == 0) ? 8'hff : (i < 3) ? 8'h00 : 8'($urandom());
      s2 = (i < 3) ? 8'h00 : 8'($urandom());
      f2 = 8'($urandom());
      gm = (i < 3) ? 1'(i == 1) : 1'($urandom());
      @(posedge CLK);
      IRQ_STATUS <= s;
      IRQ_FILTER <= f;
      SECOND_IRQ_STATUS <= s2;
      SECOND_IRQ_FILTER <= f2;
      tcc_host_model_inst.wr(8'h04, {7'h21, gm});
      repeat (2) @(posedge CLK);
      #1;
      chk(INT_N, irq_exp(s, f, s2, f2, gm));
    end
    @(posedge CLK);
    IRQ_STATUS <= 8'h00;
    SECOND_IRQ_STATUS <= 8'h00;
    // every period, duty and current code; new values from next period
    for (int i = 0; i < 4; i++) begin
      tcc_host_model_inst.wr(8'h04, {2'(i), 2'(3 - i), 1'b0, 2'(i), 1'b0});
      src_len(n);
      chk(n, src_cyc(i, 3 - i), 2);
      chk(SOURCE_PULLUP_CURRENT_SEL, (i == 0) ? 2'h1 : 2'(i));
    end
    // override walks the duty: shares latched over 500 ms apart differ, both on the 9 ms grid
    @(posedge CLK);
    FIXED_DUTY_EN <= 1'b1;
    src_len(n1);
    repeat (tcc_pkg::FIXED_DUTY_MS * MS + 100) @(posedge CLK);
    src_len(n);
    chk(n != n1, 1'b1);
    chk((n1 + 2) % (9 * MS), 2, 2);
    chk((n + 2) % (9 * MS), 2, 2);
    @(posedge CLK);
    FIXED_DUTY_EN <= 1'b0;
    // shortest, longest and reserved debounce codes
    foreach (codes[k]) begin
      tcc_host_model_inst.wr(8'h05, {5'h05, codes[k]});
      repeat (4) @(posedge CLK);
      ATTACH_RAW <= 1'b1;
      wt(3, 1, 1000, n);
      chk(n, ((codes[k] == 3'h7) ? 180 : 120 + 10 * codes[k]) * MS + 4, 6);
      @(posedge CLK);
      ATTACH_RAW <= 1'b0;
      wt(3, 0, 12, n);
    end
    // weak supply forces sink, recovery restores dual-role
    tcc_host_model_inst.wr(8'h05, 8'h3b);
    @(posedge CLK);
    VDD_LOW <= 1'b1;
    wt(0, 1, 20, n);
    chk(ROLE_WDATA, 3'h2);
    wt(1, 1, 8, n);
    @(posedge CLK);
    VDD_LOW <= 1'b0;
    wt(0, 1, 20, n);
    chk(ROLE_WDATA, 3'h4);
    wt(1, 1, 8, n);
    close_out();
  end
endmodule
`default_nettype wire

// file: rtl/tcc_cfg_regs.sv
// Purpose: toggle, source current, weak-supply and debounce configuration bank
// Assumes: register port driven by the on-chip serial-bus engine on CLK
// Notes: ATTACH_RAW and VDD_LOW come from analog comparators and are synchronised
`timescale 1ns/1ps
`default_nettype none
module tcc_cfg_regs #(
  parameter int MS_CYC = tcc_pkg::MS_CYCLES
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic REG_WE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic BUS_MODE,
  input wire logic FIXED_DUTY_EN,
  input wire logic [2:0] PORT_ROLE_CFG,
  input wire logic [7:0] IRQ_STATUS,
  input wire logic [7:0] IRQ_FILTER,
  input wire logic [7:0] SECOND_IRQ_STATUS,
  input wire logic [7:0] SECOND_IRQ_FILTER,
  input wire logic VDD_LOW,
  input wire logic ATTACH_RAW,
  output logic INT_N,
  output logic [1:0] WEAK_SUPPLY_THRESHOLD_SEL,
  output logic [1:0] SOURCE_PULLUP_CURRENT_SEL,
  output logic PRESENT_SOURCE,
  output logic ATTACH_VALID,
  output logic HOST_DISABLED_STATE,
  output logic ERR_RECOVERY,
  output logic ROLE_WR,
  output logic [2:0] ROLE_WDATA
);
  logic [7:0] tog_cfg_reg;
  logic [7:0] sup_cfg_reg;
  logic [17:0] ms_cnt_reg;
  logic ms_tick;
  logic [2:0] vdd_sync_reg;
  logic [2:0] att_sync_reg;
  logic vdd_low_reg;
  logic att_reg;
  logic [7:0] tog_ms_reg;
  logic [7:0] period_ms_reg;
  logic [7:0] sink_ms_reg;
  logic [8:0] fix_ms_reg;
  logic [1:0] auto_duty_reg;
  logic [1:0] duty_next;
  logic [7:0] deb_ms_reg;
  logic [7:0] deb_lim_reg;
  logic [3:0] role_prev_reg;
  logic [2:0] role_save_reg;
  logic fb_active_reg;
  logic role_drp;
  logic role_src;
  logic irq_any;

  localparam logic [17:0] MS_LAST = 18'(MS_CYC - 1);
  localparam logic [8:0] FIX_LAST = 9'(tcc_pkg::FIXED_DUTY_MS - 1);

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  // full byte stored so reserved bits read back [RULE15]
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tog_cfg_reg <= tcc_pkg::RST_TOGGLE_IRQ; // [RULE4]
      sup_cfg_reg <= tcc_pkg::RST_SUPPLY_DEB;
    end else if (REG_WE) begin
      if (REG_ADDR == tcc_pkg::ADDR_TOGGLE_IRQ) tog_cfg_reg <= REG_WDATA;
      if (REG_ADDR == tcc_pkg::ADDR_SUPPLY_DEB) sup_cfg_reg <= REG_WDATA;
    end
  end

  // registered read; unmapped addresses return zero
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA <= 8'h00;
    end else begin
      if (REG_ADDR == tcc_pkg::ADDR_TOGGLE_IRQ) REG_RDATA <= tog_cfg_reg;
      else if (REG_ADDR == tcc_pkg::ADDR_SUPPLY_DEB) REG_RDATA <= sup_cfg_reg;
      else REG_RDATA <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // a level counts only once stages two and three agree
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      vdd_sync_reg <= 3'h0;
      att_sync_reg <= 3'h0;
      vdd_low_reg <= 1'b0;
      att_reg <= 1'b0;
    end else begin
      vdd_sync_reg <= {vdd_sync_reg[1:0], VDD_LOW};
      att_sync_reg <= {att_sync_reg[1:0], ATTACH_RAW};
      if (vdd_sync_reg[1] == vdd_sync_reg[2]) vdd_low_reg <= vdd_sync_reg[2];
      if (att_sync_reg[1] == att_sync_reg[2]) att_reg <= att_sync_reg[2];
    end
  end

  // ------------------------------------------------------------
  // millisecond time base
  // ------------------------------------------------------------
  assign ms_tick = (ms_cnt_reg == MS_LAST);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) ms_cnt_reg <= 18'h00000;
    else if (ms_tick) ms_cnt_reg <= 18'h00000;
    else ms_cnt_reg <= ms_cnt_reg + 18'h00001;
  end

  // ------------------------------------------------------------
  // port role decode and change detect
  // ------------------------------------------------------------
  assign role_drp = PORT_ROLE_CFG[2]; // [RULE13]
  assign role_src = !PORT_ROLE_CFG[2] && !PORT_ROLE_CFG[1] && PORT_ROLE_CFG[0];

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      role_prev_reg <= 4'h0;
      ERR_RECOVERY <= 1'b0;
    end else begin
      role_prev_reg <= {1'b1, PORT_ROLE_CFG}; // top bit: sample valid, no false change after reset
      ERR_RECOVERY <= role_prev_reg[3] && (role_prev_reg[2:0] != PORT_ROLE_CFG); // [RULE13]
    end
  end

  // ------------------------------------------------------------
  // dual-role toggling
  // ------------------------------------------------------------
  // override walks the duty codes so both durations change every 500 ms
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      fix_ms_reg <= 9'h000;
      auto_duty_reg <= 2'h0;
    end else if (ms_tick) begin
      if (fix_ms_reg == FIX_LAST) begin
        fix_ms_reg <= 9'h000;
        auto_duty_reg <= auto_duty_reg + 2'h1; // [RULE12]
      end else begin
        fix_ms_reg <= fix_ms_reg + 9'h001;
      end
    end
  end

  assign duty_next = FIXED_DUTY_EN ? auto_duty_reg : tog_cfg_reg[tcc_pkg::DUTY_LSB +: 2]; // [RULE12]

  // settings latched only at period start, so a write never tears a period
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tog_ms_reg <= 8'h00;
      period_ms_reg <= 8'(tcc_pkg::PERIOD_BASE_MS + tcc_pkg::PERIOD_STEP_MS);
      sink_ms_reg <= 8'(tcc_pkg::SINK_PCT_BASE * (tcc_pkg::PERIOD_BASE_MS + tcc_pkg::PERIOD_STEP_MS) / 100);
      SOURCE_PULLUP_CURRENT_SEL <= tcc_pkg::CUR_DEFAULT;
    end else if (!role_drp || HOST_DISABLED_STATE || ATTACH_VALID ||
                 (ms_tick && tog_ms_reg >= period_ms_reg - 8'h01)) begin
      tog_ms_reg <= 8'h00;
      period_ms_reg <= 8'(tcc_pkg::PERIOD_BASE_MS) +
        8'(tcc_pkg::PERIOD_STEP_MS) * {6'h00, tog_cfg_reg[tcc_pkg::PERIOD_LSB +: 2]}; // [RULE1] [RULE16]
      // period and share are both tens, so sink ms is a product of tenths
      sink_ms_reg <= (8'(tcc_pkg::PERIOD_BASE_MS / tcc_pkg::PCT_STEP) + {6'h00, tog_cfg_reg[tcc_pkg::PERIOD_LSB +: 2]})
        * (8'(tcc_pkg::SINK_PCT_BASE / tcc_pkg::PCT_STEP) - {6'h00, duty_next}); // [RULE2]
      // reserved current code falls back to default strength
      SOURCE_PULLUP_CURRENT_SEL <= (tog_cfg_reg[tcc_pkg::CUR_LSB +: 2] == tcc_pkg::CUR_RESERVED) ?
        tcc_pkg::CUR_DEFAULT : tog_cfg_reg[tcc_pkg::CUR_LSB +: 2]; // [RULE3]
    end else if (ms_tick) begin
      tog_ms_reg <= tog_ms_reg + 8'h01;
    end
  end

  // sink share first, then source share
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) PRESENT_SOURCE <= 1'b0;
    else if (role_drp) PRESENT_SOURCE <= (tog_ms_reg >= sink_ms_reg); // [RULE2]
    else PRESENT_SOURCE <= role_src;
  end

  // ------------------------------------------------------------
  // attach debounce
  // ------------------------------------------------------------
  // limit latched while no attach is seen, i.e. at interval start
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      deb_ms_reg <= 8'h00;
      deb_lim_reg <= 8'(tcc_pkg::DEB_BASE_MS + 3 * tcc_pkg::DEB_STEP_MS);
      ATTACH_VALID <= 1'b0;
    end else if (!att_reg) begin
      deb_ms_reg <= 8'h00;
      ATTACH_VALID <= 1'b0;
      if (sup_cfg_reg[tcc_pkg::DEB_LSB +: 3] == tcc_pkg::DEB_RESERVED)
        deb_lim_reg <= 8'(tcc_pkg::DEB_MAX_MS); // [RULE11]
      else
        deb_lim_reg <= 8'(tcc_pkg::DEB_BASE_MS) +
          8'(tcc_pkg::DEB_STEP_MS) * {5'h00, sup_cfg_reg[tcc_pkg::DEB_LSB +: 3]}; // [RULE11] [RULE16]
    end else begin
      if (ms_tick && deb_ms_reg < deb_lim_reg) deb_ms_reg <= deb_ms_reg + 8'h01;
      ATTACH_VALID <= (deb_ms_reg >= deb_lim_reg); // [RULE11]
    end
  end

  // ------------------------------------------------------------
  // weak-supply sink fall-back
  // ------------------------------------------------------------
  // comparator threshold follows the field directly
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) WEAK_SUPPLY_THRESHOLD_SEL <= tcc_pkg::RST_SUPPLY_DEB[tcc_pkg::THR_LSB +: 2];
    else WEAK_SUPPLY_THRESHOLD_SEL <= sup_cfg_reg[tcc_pkg::THR_LSB +: 2]; // [RULE6]
  end

  // disabling the fall-back while active also restores the role
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      fb_active_reg <= 1'b0;
      role_save_reg <= 3'h0;
      ROLE_WR <= 1'b0;
      ROLE_WDATA <= 3'h0;
    end else begin
      ROLE_WR <= 1'b0;
      if (!fb_active_reg && vdd_low_reg && sup_cfg_reg[tcc_pkg::FALLBACK_BIT]) begin
        fb_active_reg <= 1'b1;
        role_save_reg <= PORT_ROLE_CFG; // [RULE7]
        ROLE_WR <= 1'b1;
        ROLE_WDATA <= tcc_pkg::ROLE_SINK; // [RULE7]
      end else if (fb_active_reg && (!vdd_low_reg || !sup_cfg_reg[tcc_pkg::FALLBACK_BIT])) begin
        fb_active_reg <= 1'b0;
        ROLE_WR <= 1'b1;
        ROLE_WDATA <= role_save_reg; // [RULE8]
      end
    end
  end

  // ------------------------------------------------------------
  // enable and interrupt output
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) HOST_DISABLED_STATE <= 1'b0;
    else HOST_DISABLED_STATE <= BUS_MODE && !sup_cfg_reg[tcc_pkg::ENABLE_BIT]; // [RULE9] [RULE10]
  end

  // status bits are latched upstream regardless of mask; only the pin is gated
  assign irq_any = |(IRQ_STATUS & ~IRQ_FILTER) || |(SECOND_IRQ_STATUS & ~SECOND_IRQ_FILTER); // [RULE5] [RULE14]

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) INT_N <= 1'b1;
    else INT_N <= !(irq_any && !tog_cfg_reg[tcc_pkg::GMASK_BIT]); // [RULE4] [RULE5]
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_gmask;
    @(posedge CLK) disable iff (!RSTN) tog_cfg_reg[0] |=> INT_N;
  endproperty
  a_gmask: assert property (p_gmask) else $error("interrupt passed global mask"); // [RULE4]

  property p_unmasked;
    @(posedge CLK) disable iff (!RSTN) (!tog_cfg_reg[0] && irq_any) |=> !INT_N;
  endproperty
  a_unmasked: assert property (p_unmasked) else $error("unmasked interrupt not driven"); // [RULE5]

  property p_force_sink;
    @(posedge CLK) disable iff (!RSTN) (!fb_active_reg && vdd_low_reg && sup_cfg_reg[4])
      |=> (ROLE_WR && ROLE_WDATA == 3'h2 && fb_active_reg);
  endproperty
  a_force_sink: assert property (p_force_sink) else $error("fall-back did not force sink"); // [RULE7]

  property p_restore;
    @(posedge CLK) disable iff (!RSTN) (fb_active_reg && !vdd_low_reg)
      |=> (ROLE_WR && ROLE_WDATA == $past(role_save_reg));
  endproperty
  a_restore: assert property (p_restore) else $error("role not restored"); // [RULE8]

  property p_pinmode;
    @(posedge CLK) disable iff (!RSTN) !BUS_MODE |=> !HOST_DISABLED_STATE;
  endproperty
  a_pinmode: assert property (p_pinmode) else $error("enable honoured in pin mode"); // [RULE9]

  property p_disable;
    @(posedge CLK) disable iff (!RSTN) (BUS_MODE && !sup_cfg_reg[3]) |=> HOST_DISABLED_STATE;
  endproperty
  a_disable: assert property (p_disable) else $error("disable not applied"); // [RULE10]

  property p_errrec;
    @(posedge CLK) disable iff (!RSTN) (PORT_ROLE_CFG != $past(PORT_ROLE_CFG)) |=> ERR_RECOVERY;
  endproperty
  a_errrec: assert property (p_errrec) else $error("role change without recovery"); // [RULE13]

  property p_cur;
    @(posedge CLK) disable iff (!RSTN) SOURCE_PULLUP_CURRENT_SEL != 2'h0;
  endproperty
  a_cur: assert property (p_cur) else $error("reserved current code driven"); // [RULE3]

  property p_period;
    @(posedge CLK) disable iff (!RSTN) (period_ms_reg >= 8'h3c && period_ms_reg <= 8'h5a && sink_ms_reg < period_ms_reg);
  endproperty
  a_period: assert property (p_period) else $error("toggle period out of range"); // [RULE1]
endmodule
`default_nettype wire
